// ===== verilog/tx_ring_cfg.svh
// constants for the transmit ring configuration and gap throttle
`ifndef TX_RING_CFG_SVH
`define TX_RING_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ADDR_W               16
`define OFF_GAP_THROTTLE     16'h0458
`define OFF_RING_BASE_LOW    16'h3800
`define OFF_RING_BASE_HIGH   16'h3804
`define OFF_RING_LENGTH      16'h3808
`define OFF_GAP_TIMER        16'h0410
`define OFF_RING_HEAD        16'h3810
`define OFF_RING_TAIL        16'h3818
`define OFF_STATUS           16'h3830

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define GAP_VALUE_W          16
`define B2B_GAP_W            10
`define PTR_W                16
`define LEN_LSB              7
`define LEN_MSB              19
`define BASE_LOW_LSB         4
`define DESC_SHIFT           4
`define RST_GAP_THROTTLE     16'h0000
`define RST_RING_LENGTH      13'h0000
`define RST_B2B_GAP          10'h00a
`define RST_BASE             32'h00000000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define GAP_UNIT_NS          8
`define STD_MIN_GAP_UNITS    16'h000c

`endif

// ===== verilog/tx_ring_pkg.sv
// types for the transmit ring configuration and gap throttle
package tx_ring_pkg;
    typedef enum logic [1:0] {
        GAP_IDLE  = 2'b00,
        GAP_WAIT  = 2'b01,
        GAP_SEND  = 2'b10
    } gap_state_e;
    typedef logic [63:0] addr64_t;
endpackage

// ===== verilog/gap_counter.sv
// down counter that times the spacing before a back-to-back packet
`timescale 1ns/10ps
`default_nettype none
`include "tx_ring_cfg.svh"
module gap_counter #(
    parameter int W = 17
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    output logic              done
);
    logic [W-1:0] count;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (ce) begin
            if (load) begin
                count <= load_value;
            end else if (count != '0) begin
                count <= count - W'(1);
            end
        end
    end

    assign done = (count == '0) && !load;
endmodule
`default_nettype wire

// ===== verilog/ring_addr_gen.sv
// descriptor fetch address: base plus sixteen times a wrapping index
`timescale 1ns/10ps
`default_nettype none
`include "tx_ring_cfg.svh"
module ring_addr_gen
    import tx_ring_pkg::*;
#(
    parameter int IW = 16
) (
    // ring setup
    input  wire logic [63:0]   base,
    input  wire logic [12:0]   len_units,
    // index
    input  wire logic [IW-1:0] index,
    output logic [IW-1:0]      next_index,
    output addr64_t            fetch_addr
);
    logic [IW-1:0] desc_count;
    logic [IW-1:0] inc;

    // 128-byte units hold eight descriptors each
    assign desc_count = IW'({len_units, 3'b000});
    assign inc        = index + IW'(1);
    assign next_index = (inc >= desc_count) ? '0 : inc;
    assign fetch_addr = base + {{(64-IW-`DESC_SHIFT){1'b0}}, index, 4'h0};
endmodule
`default_nettype wire

// ===== verilog/tx_ring_config_ifs_throttle.sv
// transmit ring configuration registers and adaptive gap throttle
//
// Operation
// (RULE1) hold back-to-back packets, delay hand-off to transmit function by gap value
// (RULE2) gap value is bits 15:0, 8 ns steps, resets to zero
// (RULE3) total back-to-back spacing is gap value plus back-to-back gap time
// (RULE4) no extra delay after a receive or for non back-to-back sends
// (RULE5) collision retransmission timing is left unchanged
// (RULE6) gap value acts only when above the standard minimum spacing
// (RULE7) software keeps gap value zero unless extra spacing is wanted
// (RULE8) gap bits 31:16 and length bits 31:20 read zero
// (RULE9) ring base low bits 3:0 ignore writes, read zero
// (RULE10) software aligns the ring base to 16 bytes
// (RULE11) ring base low holds address bits 31:4
// (RULE12) ring base high holds address bits 63:32
// (RULE13) combined 64-bit base is the first ring entry
// (RULE14) software programs length as multiple of 128 bytes
// (RULE15) length bits 6:0 ignore writes, read zero
// (RULE16) length bits 19:7 hold ring byte count, reset zero
// (RULE17) transmit descriptors from head up to but excluding tail
// (RULE18) fetch address is base plus 16 times index, wrapping at length
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "tx_ring_cfg.svh"
module tx_ring_config_ifs_throttle
    import tx_ring_pkg::*;
#(
    parameter int GAP_W = `GAP_VALUE_W
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // transmit path, same clock
    input  wire logic        pkt_waiting,
    input  wire logic        pkt_back_to_back,
    input  wire logic        after_receive,
    input  wire logic        retransmit,
    output logic             pkt_handoff,
    // descriptor fetch, same clock
    output logic             fetch_req,
    output logic [63:0]      fetch_addr,
    input  wire logic        fetch_done
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [GAP_W-1:0]     gap_value;
    logic [`B2B_GAP_W-1:0] back_to_back_gap_time;
    logic [31:4]          base_low;
    logic [31:0]          base_high;
    logic [12:0]          ring_byte_count;
    logic [15:0]          head_ptr;
    logic [15:0]          tail_ptr;
    gap_state_e           state;
    logic                 wr_en;
    logic                 rd_en;
    logic                 hit;
    logic [31:0]          next_prdata;
    logic [63:0]          ring_base;
    logic [15:0]          next_head;
    logic [63:0]          next_fetch_addr;
    logic                 load;
    logic [GAP_W:0]       load_value;
    logic                 done;
    logic                 fetch_busy;
    logic                 head_wr;

    assign wr_en = psel && penable && pwrite && !pready && ce;
    assign head_wr = wr_en && (paddr == `OFF_RING_HEAD);
    assign rd_en = psel && penable && !pwrite && !pready && ce;
    assign ring_base = {base_high, base_low, 4'h0}; // RULE13

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_value             <= `RST_GAP_THROTTLE; // RULE2
            back_to_back_gap_time <= `RST_B2B_GAP;
            base_low              <= 28'h0000000;
            base_high             <= `RST_BASE;
            ring_byte_count       <= `RST_RING_LENGTH; // RULE16
            tail_ptr              <= 16'h0000;
        end else if (wr_en) begin
            case (paddr)
                `OFF_GAP_THROTTLE:   gap_value <= pwdata[GAP_W-1:0]; // RULE2
                `OFF_GAP_TIMER:      back_to_back_gap_time <= pwdata[`B2B_GAP_W-1:0];
                `OFF_RING_BASE_LOW:  base_low <= pwdata[31:4]; // RULE9 RULE11
                `OFF_RING_BASE_HIGH: base_high <= pwdata; // RULE12
                `OFF_RING_LENGTH:    ring_byte_count <= pwdata[`LEN_MSB:`LEN_LSB]; // RULE15 RULE16
                `OFF_RING_TAIL:      tail_ptr <= pwdata[15:0];
                default:             ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read mux and apb answer
    // ----------------------------------------------------------------
    always_comb begin
        next_prdata = 32'h00000000;
        hit = 1'b1;
        case (paddr)
            `OFF_GAP_THROTTLE:   next_prdata = {16'h0000, gap_value}; // RULE8
            `OFF_GAP_TIMER:      next_prdata = {22'h000000, back_to_back_gap_time};
            `OFF_RING_BASE_LOW:  next_prdata = {base_low, 4'h0}; // RULE9
            `OFF_RING_BASE_HIGH: next_prdata = base_high;
            `OFF_RING_LENGTH:    next_prdata = {12'h000, ring_byte_count, 7'h00}; // RULE8 RULE15
            `OFF_RING_HEAD:      next_prdata = {16'h0000, head_ptr};
            `OFF_RING_TAIL:      next_prdata = {16'h0000, tail_ptr};
            `OFF_STATUS:         next_prdata = {29'h00000000, fetch_busy, state};
            default:             hit = 1'b0;
        endcase
    end

    // one wait state: answer lands the edge after the first access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (ce) begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !hit;
            prdata  <= rd_en ? next_prdata : 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // gap throttle
    // ----------------------------------------------------------------
    // only back-to-back first attempts get the extra gap
    always_comb begin
        load_value = '0;
        if (pkt_back_to_back && !after_receive && !retransmit) begin // RULE4 RULE5
            if (gap_value > `STD_MIN_GAP_UNITS) begin // RULE6
                load_value = (GAP_W+1)'(gap_value) + (GAP_W+1)'(back_to_back_gap_time); // RULE3
            end else begin
                load_value = (GAP_W+1)'(back_to_back_gap_time);
            end
        end
    end

    assign load = (state == GAP_IDLE) && pkt_waiting;

    gap_counter #(
        .W (GAP_W+1)
    ) u_gap (
        .pclk       (pclk),
        .presetn    (presetn),
        .ce         (ce),
        .load       (load),
        .load_value (load_value),
        .done       (done)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= GAP_IDLE;
            pkt_handoff <= 1'b0;
        end else if (ce) begin
            pkt_handoff <= 1'b0;
            case (state)
                GAP_IDLE: if (pkt_waiting) state <= GAP_WAIT; // RULE1
                GAP_WAIT: if (done) begin
                    pkt_handoff <= 1'b1; // RULE1
                    state       <= GAP_SEND;
                end
                GAP_SEND: state <= GAP_IDLE;
                default:  state <= GAP_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // descriptor walk
    // ----------------------------------------------------------------
    ring_addr_gen #(
        .IW (16)
    ) u_addr (
        .base       (ring_base),
        .len_units  (ring_byte_count),
        .index      (head_ptr),
        .next_index (next_head),
        .fetch_addr (next_fetch_addr)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            head_ptr   <= 16'h0000;
            fetch_req  <= 1'b0;
            fetch_addr <= 64'h0000000000000000;
            fetch_busy <= 1'b0;
        end else if (ce) begin
            fetch_req <= 1'b0;
            if (head_wr) begin
                head_ptr <= pwdata[15:0];
            end else if (fetch_busy && fetch_done) begin
                head_ptr <= next_head; // RULE18
            end
            // a head write must not swallow a fetch completion, or busy sticks high
            if (fetch_busy && fetch_done) begin
                fetch_busy <= 1'b0;
            end else if (!fetch_busy && !head_wr && head_ptr != tail_ptr
                         && ring_byte_count != 13'h0000) begin // RULE17
                fetch_req  <= 1'b1;
                fetch_addr <= next_fetch_addr; // RULE18
                fetch_busy <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/tx_ring_chk.sv
// port checker for the ring configuration and gap throttle
`timescale 1ns/10ps
`default_nettype none
`include "tx_ring_cfg.svh"
module tx_ring_chk (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // transmit and fetch
    input wire logic        pkt_waiting,
    input wire logic        pkt_handoff,
    input wire logic        fetch_req,
    input wire logic [63:0] fetch_addr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence s_access;
        psel && penable && !pready && ce;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    sequence s_rd;
        pready && !pwrite;
    endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_one_wait: assert property (s_access |=> s_answer)
        else $error("answer not one cycle after access");
    a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_err_answer: assert property (pslverr |-> pready)
        else $error("error without answer");
    a_gap_resv: assert property (s_rd and paddr == `OFF_GAP_THROTTLE |-> prdata[31:16] == 16'h0)
        else $error("gap upper half not zero");
    a_len_resv: assert property (s_rd and paddr == `OFF_RING_LENGTH |-> prdata[31:20] == 12'h0)
        else $error("length upper bits not zero");
    a_len_zero: assert property (s_rd and paddr == `OFF_RING_LENGTH |-> prdata[6:0] == 7'h0)
        else $error("length low bits not zero");
    a_base_low: assert property (s_rd and paddr == `OFF_RING_BASE_LOW |-> prdata[3:0] == 4'h0)
        else $error("base low bits not zero");
    a_handoff_pulse: assert property (pkt_handoff |-> $past(pkt_waiting) ##1 !pkt_handoff)
        else $error("handoff without packet or too long");
    a_fetch_align: assert property (fetch_req |-> fetch_addr[3:0] == 4'h0 ##1 !fetch_req)
        else $error("fetch address not aligned");
endmodule
bind tx_ring_config_ifs_throttle tx_ring_chk u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pkt_waiting(pkt_waiting), .pkt_handoff(pkt_handoff), .fetch_req(fetch_req), .fetch_addr(fetch_addr));
`default_nettype wire

// ===== tb/tb_tx_ring_config_ifs_throttle.sv
// self-checking bench for the ring configuration and gap throttle
`timescale 1ns/10ps
`default_nettype none
`include "tx_ring_cfg.svh"
module tb_tx_ring_config_ifs_throttle;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0;
    logic        pkt_waiting = 1'b0;
    logic        b2b = 1'b0;
    logic        after_rx = 1'b0;
    logic        retx = 1'b0;
    logic        fetch_done = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pkt_handoff;
    logic        fetch_req;
    logic [63:0] fetch_addr;
    logic [31:0] rd;
    logic        err;
    int          comparisons = 0;
    int          n_mismatch = 0;
    int          base_n;
    int          n;
    logic [15:0] gv [6] = '{16'h0, 16'h000c, 16'h000d, 16'h0040, 16'h0040, 16'h0040};
    logic [2:0]  q [6] = '{3'b100, 3'b100, 3'b100, 3'b000, 3'b110, 3'b101};
    int          ex [6] = '{10, 10, 23, 0, 0, 0};
    always #25 pclk = ~pclk;
    tx_ring_config_ifs_throttle uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pkt_waiting(pkt_waiting), .pkt_back_to_back(b2b), .after_receive(after_rx), .retransmit(retx),
        .pkt_handoff(pkt_handoff), .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_done(fetch_done));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // hold the request until pready is sampled high
    task apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rchk(input string name, input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask
    task wr_rd(input string name, input logic [15:0] a, input logic [31:0] d, input logic [31:0] exp);
        apb(1'b1, a, d);
        rchk(name, a, exp);
    endtask
    // cycles from request to handoff; only differences are compared
    task pkt(input logic [2:0] k, output int c);
        @(posedge pclk);
        pkt_waiting <= 1'b1;
        {b2b, after_rx, retx} <= k;
        for (c = 0; c < 300; c++) begin
            @(posedge pclk);
            if (pkt_handoff === 1'b1) break;
        end
        pkt_waiting <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task fwait(input logic [63:0] exp);
        int i;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (fetch_req === 1'b1) break;
        end
        check("fetch address", fetch_req ? fetch_addr : 64'h0, exp);
        fetch_done <= 1'b1;
        @(posedge pclk);
        fetch_done <= 1'b0;
    endtask
    task results;
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        #(50 * 40000);
        n_mismatch++;
        results;
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rchk("gap reset", `OFF_GAP_THROTTLE, 32'h0);
        rchk("length reset", `OFF_RING_LENGTH, 32'h0);
        rchk("gap time reset", `OFF_GAP_TIMER, 32'h0000000a);
        wr_rd("gap", `OFF_GAP_THROTTLE, 32'hffffffff, 32'h0000ffff);
        wr_rd("length", `OFF_RING_LENGTH, 32'hffffffff, 32'h000fff80);
        wr_rd("base low", `OFF_RING_BASE_LOW, 32'hffffffff, 32'hfffffff0);
        wr_rd("base high", `OFF_RING_BASE_HIGH, 32'h89abcdef, 32'h89abcdef);
        apb(1'b1, 16'h0100, 32'hffffffff);
        check("unmapped write", err, 1'b1);
        rchk("unmapped read", 16'h0100, 32'h0);
        check("unmapped read error", err, 1'b1);
        apb(1'b1, `OFF_GAP_THROTTLE, 32'h0);
        pkt(3'b000, base_n);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, `OFF_GAP_THROTTLE, {16'h0, gv[i]});
            pkt(q[i], n);
            check("gap delay", n - base_n, ex[i]);
        end
        // clock enable low freezes the throttle with a packet waiting
        ce <= 1'b0;
        pkt_waiting <= 1'b1;
        {b2b, after_rx, retx} <= 3'b000;
        repeat (5) @(posedge pclk);
        check("frozen handoff", pkt_handoff, 1'b0);
        ce <= 1'b1;
        repeat (3) @(posedge pclk);
        check("thawed handoff", pkt_handoff, 1'b1);
        pkt_waiting <= 1'b0;
        repeat (3) @(posedge pclk);
        apb(1'b1, `OFF_GAP_THROTTLE, 32'h0);
        // length zero first so no fetch starts on a half-built ring
        apb(1'b1, `OFF_RING_LENGTH, 32'h0);
        apb(1'b1, `OFF_RING_BASE_HIGH, 32'h00000001);
        apb(1'b1, `OFF_RING_BASE_LOW, 32'h00001000);
        apb(1'b1, `OFF_RING_HEAD, 32'h0000000f);
        apb(1'b1, `OFF_RING_TAIL, 32'h00000001);
        apb(1'b1, `OFF_RING_LENGTH, 32'h00000100);
        fwait(64'h00000001000010f0);
        fwait(64'h0000000100001000);
        rchk("head", `OFF_RING_HEAD, 32'h00000001);
        rchk("status", `OFF_STATUS, 32'h0);
        check("mapped read error", err, 1'b0);
        // second reset in mid-run: programmed values must clear
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk("length after reset", `OFF_RING_LENGTH, 32'h0);
        rchk("head after reset", `OFF_RING_HEAD, 32'h0);
        results;
    end
endmodule
`default_nettype wire
